// ---- core/chg_regs.svh ----
// timing constants and encodings for the charger status sequencer
// assumes a 200 MHz core clock
`ifndef CHG_REGS_SVH
`define CHG_REGS_SVH
`define CHG_CLK_HZ 200000000
`define CHG_BLINK_HZ_X10 5
// half period of 0.5 Hz blink: one second
`define CHG_BLINK_HALF ((`CHG_CLK_HZ * 10) / (`CHG_BLINK_HZ_X10 * 2))
// probe interval in microseconds, default value for the absence test
`define CHG_PROBE_US 250000
`define CHG_PROBE_CYC ((`CHG_CLK_HZ / 1000000) * `CHG_PROBE_US)
// precharge and fast charge safety timer defaults, in cycles
`define CHG_PRE_TMO 32'h0BEB_C200
`define CHG_FAST_TMO 32'h2FAF_0800
`endif

// ---- core/chg_pkg.sv ----
// types shared by the charger status sequencer
// assumes chg_regs.svh supplies numeric constants
package chg_pkg;
   typedef enum logic [3:0] {
      CHG_SLEEP = 4'h0,
      CHG_PRE = 4'h1,
      CHG_FAST = 4'h3,
      CHG_REG = 4'h2,
      CHG_DONE = 4'h6,
      CHG_PROBE1 = 4'h7,
      CHG_PROBE2 = 4'h5,
      CHG_ABSENT = 4'h4,
      CHG_TFAULT = 4'hC,
      CHG_OVP = 4'hD,
      CHG_SUSP = 4'hF,
      CHG_DISABLED = 4'hE
   } chg_state_t;
   typedef struct packed {
      logic above_refill;
      logic below_deep;
      logic at_float;
      logic over_volt;
      logic below_short;
      logic term_current;
   } chg_sense_t;
   typedef struct packed {
      logic pwm_enable;
      logic probe_current;
      logic precharge_rate;
      logic fast_rate;
   } chg_drive_t;
endpackage

// ---- core/chg_status_seq.sv ----
// charger control and status sequencer: state, timers, indicators
// assumes analog comparators on sense inputs and open-drain pads outside
// How it works
// - charging: a on b off; complete: b on; other states both off
// - blink variant, stand-alone only: a toggles 0.5 Hz for short while charging, suspend, timer faults
// - system variant has no timer-fault or battery-absent status
// - adapter good on after sleep exit, off in sleep
// - enable input low allows charging, high disables it
// - enable falling edge resets timers and clears latched faults
// - after charge complete, drop to refill level starts absence test
// - phase one: probe current for interval, check below deep level
// - phase two: precharge current for interval, check above refill
// - both pass gives absent fault; any fail restarts charging
// - timer fault above refill waits drop, then clears into test
// - timer fault also cleared by reset, enable or timer cap toggle
// - timer fault below refill: probe current on until above refill
// - overvoltage stops pwm, indicators off, clears at refill drop
// - system variant: rate select low precharge, high fast rate
// - float level enters voltage regulation regardless of rate select
// - system variant: no termination, no safety timers
// - system variant: overvoltage halts charge, all switches off
// - precharge timeout: stop, fault, reduce to probe current
// - suspend stops pwm and holds timers
// - timer cap low disables timer; rising re-enables and resets
`timescale 1ns/1ps
`include "chg_regs.svh"
module chg_status_seq #(
   parameter bit SYS_CTRL = 1'b0,
   parameter bit BLINK_VARIANT = 1'b0,
   parameter int unsigned BLINK_HALF = `CHG_BLINK_HALF,
   parameter int unsigned PROBE_CYC = `CHG_PROBE_CYC,
   parameter int unsigned PRE_TMO = `CHG_PRE_TMO,
   parameter int unsigned FAST_TMO = `CHG_FAST_TMO
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // pins and comparators
   input wire logic charge_enable_n_in,
   input wire logic rate_select_in,
   input wire logic safety_timer_cap_in,
   input wire logic supply_ok_in,
   input wire logic suspend_in,
   input wire chg_pkg::chg_sense_t sense_in,
   // indicators, open drain: oe high pulls the pin low
   output logic indicator_a_oe_out,
   output logic indicator_b_oe_out,
   output logic adapter_good_n_oe_out,
   // power stage
   output chg_pkg::chg_drive_t drive_out
);
   // two-flop synchronisers for every asynchronous input
   // both stages reset to the idle pin levels (enable high, timer cap high)
   // so that no false edge of either pin follows reset
   localparam int NS = 11;
   localparam logic [NS-1:0] SYNC_IDLE = 11'h500;
   logic [NS-1:0] raw, s1_r, s2_r;
   assign raw = {charge_enable_n_in, rate_select_in, safety_timer_cap_in,
                 supply_ok_in, suspend_in, sense_in};
   genvar gi;
   for (gi = 0; gi < NS; gi++) begin : g_sync
      always_ff @(posedge clock_in or posedge rst_in) begin
         if (rst_in) begin
            s1_r[gi] <= SYNC_IDLE[gi];
            s2_r[gi] <= SYNC_IDLE[gi];
         end else begin
            s1_r[gi] <= raw[gi];
            s2_r[gi] <= s1_r[gi];
         end
      end
   end
   logic ce_n, rsel, cap, vok, susp;
   chg_pkg::chg_sense_t sn;
   assign {ce_n, rsel, cap, vok, susp, sn} = s2_r;

   chg_pkg::chg_state_t st_r, st_nxt;
   logic ce_prev_r, cap_prev_r, blink_r, blink_nxt, tmo_en_r;
   logic [31:0] tmr_r, tmr_nxt, blk_r, blk_nxt;
   logic a_r, a_nxt, b_r, b_nxt, pg_r, pg_nxt;
   chg_pkg::chg_drive_t drv_r, drv_nxt;
   logic ce_fall, cap_rise, cap_fall;
   assign ce_fall = ce_prev_r & ~ce_n;
   assign cap_rise = ~cap_prev_r & cap;
   assign cap_fall = cap_prev_r & ~cap;

   // charging states count as in progress for the indicator
   function automatic logic is_charging(input chg_pkg::chg_state_t s);
      return s == chg_pkg::CHG_PRE || s == chg_pkg::CHG_FAST ||
             s == chg_pkg::CHG_REG;
   endfunction

   always_comb begin
      st_nxt = st_r;
      tmr_nxt = tmr_r;
      if (!vok) begin
         st_nxt = chg_pkg::CHG_SLEEP;
         tmr_nxt = '0;
      end else if (ce_fall) begin
         st_nxt = sn.below_deep ? chg_pkg::CHG_PRE : chg_pkg::CHG_FAST;
         tmr_nxt = '0;
      end else if (ce_n) begin
         st_nxt = chg_pkg::CHG_DISABLED;
      end else if (sn.over_volt && st_r != chg_pkg::CHG_OVP) begin
         st_nxt = chg_pkg::CHG_OVP;
      end else if (!SYS_CTRL && (cap_rise || cap_fall) &&
                   st_r == chg_pkg::CHG_TFAULT) begin
         st_nxt = chg_pkg::CHG_PRE;
         tmr_nxt = '0;
      end else if (cap_rise) begin
         tmr_nxt = '0;
      end else if (susp && is_charging(st_r)) begin
         st_nxt = chg_pkg::CHG_SUSP;
      end else begin
         case (st_r)
            chg_pkg::CHG_SLEEP,
            chg_pkg::CHG_DISABLED:
               st_nxt = sn.below_deep ? chg_pkg::CHG_PRE : chg_pkg::CHG_FAST;
            chg_pkg::CHG_SUSP: if (!susp) begin
               st_nxt = sn.below_deep ? chg_pkg::CHG_PRE : chg_pkg::CHG_FAST;
            end
            chg_pkg::CHG_PRE, chg_pkg::CHG_FAST: begin
               tmr_nxt = tmr_r + 32'h0000_0001;
               if (sn.at_float) begin
                  st_nxt = chg_pkg::CHG_REG;
               end else if (SYS_CTRL) begin
                  st_nxt = rsel ? chg_pkg::CHG_FAST : chg_pkg::CHG_PRE;
               end else if (st_r == chg_pkg::CHG_PRE && !sn.below_deep) begin
                  st_nxt = chg_pkg::CHG_FAST;
               end else if (tmo_en_r && tmr_r >= (st_r == chg_pkg::CHG_PRE ?
                            PRE_TMO : FAST_TMO)) begin
                  st_nxt = chg_pkg::CHG_TFAULT;
                  // a cleared timer marks a fault not yet seen above refill
                  tmr_nxt = '0;
               end
            end
            chg_pkg::CHG_REG: begin
               tmr_nxt = tmr_r + 32'h0000_0001;
               if (!SYS_CTRL && tmo_en_r && sn.term_current) begin
                  st_nxt = chg_pkg::CHG_DONE;
               end else if (!SYS_CTRL && tmo_en_r && tmr_r >= FAST_TMO) begin
                  st_nxt = chg_pkg::CHG_TFAULT;
                  tmr_nxt = '0;
               end
            end
            chg_pkg::CHG_DONE: if (!sn.above_refill) begin
               st_nxt = chg_pkg::CHG_PROBE1;
               tmr_nxt = '0;
            end
            chg_pkg::CHG_PROBE1: begin
               tmr_nxt = tmr_r + 32'h0000_0001;
               if (tmr_r >= PROBE_CYC - 1) begin
                  st_nxt = sn.below_deep ? chg_pkg::CHG_PROBE2
                                         : chg_pkg::CHG_PRE;
                  tmr_nxt = '0;
               end
            end
            chg_pkg::CHG_PROBE2: begin
               tmr_nxt = tmr_r + 32'h0000_0001;
               if (tmr_r >= PROBE_CYC - 1) begin
                  st_nxt = sn.above_refill ? chg_pkg::CHG_ABSENT
                                           : chg_pkg::CHG_PRE;
                  tmr_nxt = '0;
               end
            end
            chg_pkg::CHG_ABSENT: if (!sn.above_refill) begin
               st_nxt = chg_pkg::CHG_PROBE1;
            end
            chg_pkg::CHG_TFAULT: if (sn.above_refill) begin
               tmr_nxt = 32'h0000_0001;
            end else if (tmr_r != '0) begin
               st_nxt = chg_pkg::CHG_PROBE1;
               tmr_nxt = '0;
            end
            // the comparator must fall first, or the state would chatter
            chg_pkg::CHG_OVP: if (!sn.over_volt && !sn.above_refill) begin
               st_nxt = chg_pkg::CHG_FAST;
            end
            default: st_nxt = chg_pkg::CHG_SLEEP;
         endcase
      end
   end

   // outputs and blink divider
   always_comb begin
      blk_nxt = blk_r + 32'h0000_0001;
      blink_nxt = blink_r;
      if (blk_r >= BLINK_HALF - 1) begin
         blk_nxt = '0;
         blink_nxt = ~blink_r;
      end
      a_nxt = is_charging(st_nxt);
      b_nxt = st_nxt == chg_pkg::CHG_DONE;
      if (BLINK_VARIANT && !SYS_CTRL && (st_nxt == chg_pkg::CHG_SUSP ||
          st_nxt == chg_pkg::CHG_TFAULT || (sn.below_short &&
          is_charging(st_nxt)))) begin
         a_nxt = blink_r;
      end
      if (st_nxt == chg_pkg::CHG_OVP || sn.over_volt) begin
         a_nxt = 1'b0;
         b_nxt = 1'b0;
      end
      pg_nxt = vok;
      drv_nxt.pwm_enable = is_charging(st_nxt) ||
                           st_nxt == chg_pkg::CHG_PROBE2;
      drv_nxt.probe_current = st_nxt == chg_pkg::CHG_PROBE1 ||
         (st_nxt == chg_pkg::CHG_TFAULT && !sn.above_refill &&
          tmr_nxt == '0);
      drv_nxt.precharge_rate = st_nxt == chg_pkg::CHG_PRE ||
                               st_nxt == chg_pkg::CHG_PROBE2;
      drv_nxt.fast_rate = st_nxt == chg_pkg::CHG_FAST;
      // suspend or overvoltage cut switching at once, even on a restart
      if (susp || sn.over_volt) begin
         drv_nxt.pwm_enable = 1'b0;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= chg_pkg::CHG_SLEEP;
         tmr_r <= '0;
         blk_r <= '0;
         blink_r <= 1'b0;
         ce_prev_r <= 1'b1;
         cap_prev_r <= 1'b1;
         tmo_en_r <= 1'b0;
         a_r <= 1'b0;
         b_r <= 1'b0;
         pg_r <= 1'b0;
         drv_r <= '0;
      end else begin
         st_r <= st_nxt;
         tmr_r <= tmr_nxt;
         blk_r <= blk_nxt;
         blink_r <= blink_nxt;
         ce_prev_r <= ce_n;
         cap_prev_r <= cap;
         tmo_en_r <= cap && !SYS_CTRL;
         a_r <= a_nxt;
         b_r <= b_nxt;
         pg_r <= pg_nxt;
         drv_r <= drv_nxt;
      end
   end
   // system variant never enters the timer-fault or absent states
   assign indicator_a_oe_out = a_r;
   assign indicator_b_oe_out = b_r;
   assign adapter_good_n_oe_out = pg_r;
   assign drive_out = drv_r;
endmodule // chg_status_seq

// ---- testbench/chg_status_seq_properties.sv ----
// port checker for the charger sequencer, bound at the foot
// assumes the steady-indicator stand-alone build
`timescale 1ns/1ps
module chg_status_seq_properties (
   // clock, reset, inputs and outputs of the sequencer
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic charge_enable_n_in,
   input wire logic supply_ok_in,
   input wire logic suspend_in,
   input wire chg_pkg::chg_sense_t sense_in,
   input wire logic indicator_a_oe_out,
   input wire logic indicator_b_oe_out,
   input wire logic adapter_good_n_oe_out,
   input wire chg_pkg::chg_drive_t drive_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   ind_excl_a: assert property (!(indicator_a_oe_out &&
      indicator_b_oe_out)) else $error("both indicators on");
   sleep_off_a: assert property ((!supply_ok_in)[*5] |->
      !adapter_good_n_oe_out) else $error("pg on in sleep");
   pg_on_a: assert property (supply_ok_in[*7] |->
      adapter_good_n_oe_out) else $error("pg off with supply");
   disable_stop_a: assert property (charge_enable_n_in[*6] |->
      !drive_out.pwm_enable) else $error("pwm on while disabled");
   enable_start_a: assert property ($fell(charge_enable_n_in) ##0
      (!charge_enable_n_in && supply_ok_in && !suspend_in &&
      !sense_in.over_volt && !sense_in.at_float)[*6] |->
      drive_out.pwm_enable && indicator_a_oe_out) else $error("no restart");
   ovp_stop_a: assert property (sense_in.over_volt[*5] |->
      !drive_out.pwm_enable && !indicator_a_oe_out && !indicator_b_oe_out)
      else $error("overvoltage left outputs on");
   susp_stop_a: assert property (suspend_in[*5] |->
      !drive_out.pwm_enable) else $error("pwm on in suspend");
   rate_one_a: assert property (!(drive_out.precharge_rate &&
      drive_out.fast_rate)) else $error("both rates on");
endmodule // chg_status_seq_properties
bind chg_status_seq chg_status_seq_properties chk (.clock_in, .rst_in,
   .charge_enable_n_in, .supply_ok_in, .suspend_in, .sense_in,
   .indicator_a_oe_out, .indicator_b_oe_out, .adapter_good_n_oe_out,
   .drive_out);

// ---- testbench/chg_batt_model.sv ----
// battery pack model feeding the sequencer comparators
// assumes the sequencer drive outputs on the same clock
`timescale 1ns/1ps
module chg_batt_model (
   // clock, test controls, power stage in, comparators out
   input wire logic clock_in,
   input wire logic present_in,
   input wire logic stuck_in,
   input wire logic ovp_in,
   input wire chg_pkg::chg_drive_t drive_in,
   output chg_pkg::chg_sense_t sense_out
);
   int v = 0;
   // an empty slot reads low under the probe sink, high under precharge
   always @(posedge clock_in) begin
      if (stuck_in || (!present_in && !drive_in.precharge_rate))
         v <= 0;
      else if (!present_in)
         v <= 90;
      else
         v <= drive_in.pwm_enable ? (v < 100 ? v + 1 : v)
            : (v > 0 ? v - 1 : 0);
   end
   assign sense_out = {v > 80, v < 20, v >= 100, ovp_in, v < 5,
      present_in && v >= 100};
endmodule // chg_batt_model

// ---- testbench/chg_status_seq_tb.sv ----
// self-checking bench for the charger sequencer
// assumes the battery model and the bound checker
`timescale 1ns/1ps
module chg_status_seq_tb;
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin \
   err_total++; $display("Error %s exp %0h got %0h", nm, e, s); end end
   logic clock_in = 1'h0, rst_in = 1'h1, ce_n = 1'h1, rate = 1'h0;
   logic cap = 1'h1, supply = 1'h1, susp = 1'h0, ovp = 1'h0, ia, ib;
   logic present = 1'h1, stuck = 1'h0, pg;
   chg_pkg::chg_sense_t sense;
   chg_pkg::chg_drive_t drive;
   int err_total = 0, check_count = 0, n, r;
   chg_status_seq #(.BLINK_HALF(8), .PROBE_CYC(4), .PRE_TMO(40),
      .FAST_TMO(400)) dut (.clock_in, .rst_in, .charge_enable_n_in(ce_n),
      .rate_select_in(rate), .safety_timer_cap_in(cap), .supply_ok_in(supply),
      .suspend_in(susp), .sense_in(sense), .indicator_a_oe_out(ia),
      .indicator_b_oe_out(ib), .adapter_good_n_oe_out(pg), .drive_out(drive));
   chg_batt_model batt (.clock_in, .present_in(present), .stuck_in(stuck),
      .ovp_in(ovp), .drive_in(drive), .sense_out(sense));
   initial forever #2.5 clock_in = ~clock_in;
   // a cell held low stays in precharge, so only these stop the charge
   function automatic logic run_exp(input logic s, input logic o);
      return !s && !o;
   endfunction
   // read one ns past the edge so registered outputs have landed
   task automatic cyc(input int k);
      repeat (k) @(posedge clock_in);
      #1;
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wait_ind(input logic a, input logic b, input int lim);
      for (n = 0; n < lim && {ia, ib} !== {a, b}; n++) cyc(1);
      `CHK("indicator pair", {a, b}, {ia, ib})
      if (n >= lim) complete_run();
   endtask
   initial begin
      r = $urandom(69451);
      cyc(16);
      rst_in <= 1'h0;
      cyc(8);
      ce_n <= 1'h0;
      wait_ind(1'h1, 1'h0, 10);
      wait_ind(1'h0, 1'h1, 400);
      wait_ind(1'h1, 1'h0, 100);
      wait_ind(1'h0, 1'h1, 400);
      present <= 1'h0;
      cyc(40);
      wait_ind(1'h0, 1'h0, 1);
      {present, stuck, ce_n} <= 3'h7;
      cyc(4);
      ce_n <= 1'h0;
      wait_ind(1'h1, 1'h0, 10);
      wait_ind(1'h0, 1'h0, 60);
      `CHK("probe", 1'h1, drive.probe_current)
      cap <= 1'h0;
      cyc(4);
      cap <= 1'h1;
      wait_ind(1'h1, 1'h0, 10);
      supply <= 1'h0;
      cyc(6);
      `CHK("adapter good", 1'h0, pg)
      supply <= 1'h1;
      cyc(4);
      `CHK("adapter good", 1'h1, pg)
      $display("test fixed sequences ended");
      for (int i = 0; i < 16; i++) begin
         r = $urandom;
         ce_n <= 1'h1;
         cyc(4);
         {ce_n, susp, ovp, rate, cap} <= {1'h0, r[0] & r[1], r[2] & r[3],
            r[5:4]};
         cyc(6);
         `CHK("pwm", run_exp(susp, ovp), drive.pwm_enable)
         `CHK("indicator a", run_exp(susp, ovp), ia)
      end
      $display("test random enable mix ended");
      complete_run();
   end
endmodule // chg_status_seq_tb
